/* pxpc_top.sv */
// Crossover and polarity control register with its mode decode.
// Assumes synchronous straps and status inputs and a classic Wishbone master.
`timescale 1ns/100ps
module pxpc_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Straps and status
   input  wire logic        auto_strap_i,
   input  wire logic        manual_strap_i,
   input  wire logic        fiber_mode_i,
   input  wire logic        polarity_reversed_i,
   // Controls to the PHY
   output logic      [1:0]  crossover_mode_o,
   output logic             heartbeat_test_disable_o,
   output logic             far_end_fault_enable_o
);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic        src_ff,    nxt_src;
   logic        auto_ff,   nxt_auto;
   logic        manual_ff, nxt_manual;
   logic        sqe_ff,    nxt_sqe;
   logic        fef_ff,    nxt_fef;
   logic        pol_ff,    nxt_pol;
   logic        strap_ff,  nxt_strap;
   logic        ack_ff,    nxt_ack;
   logic [31:0] dat_ff,    nxt_dat;
   logic [1:0]  mode_ff,   nxt_mode;
   logic        req;
   logic        wr_lo;
   logic        wr_hi;
   logic        srst;
   logic [15:0] ctrl_rd;

   // Single-cycle answer; ack drops the cycle after it is given
   assign req   = cyc_i && stb_i && !ack_ff;
   assign wr_lo = req && we_i && sel_i[0] && adr_i == pxpc_pkg::PXPC_CTRL_ADDR;
   assign wr_hi = req && we_i && sel_i[1] && adr_i == pxpc_pkg::PXPC_CTRL_ADDR;
   // Self-clearing PHY soft reset strobe
   assign srst  = req && we_i && sel_i[0] && adr_i == pxpc_pkg::PXPC_RSTCTL_ADDR
                  && dat_i[pxpc_pkg::PXPC_SRST_BIT];

   always_comb begin
      ctrl_rd = 16'h0000;
      ctrl_rd[pxpc_pkg::PXPC_SRC_BIT]    = src_ff;
      ctrl_rd[pxpc_pkg::PXPC_AUTO_BIT]   = auto_ff;
      ctrl_rd[pxpc_pkg::PXPC_MANUAL_BIT] = manual_ff;
      ctrl_rd[pxpc_pkg::PXPC_SQE_BIT]    = sqe_ff;
      ctrl_rd[pxpc_pkg::PXPC_FEF_BIT]    = fef_ff;
      ctrl_rd[pxpc_pkg::PXPC_POL_BIT]    = pol_ff;
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      nxt_src    = src_ff;
      nxt_auto   = auto_ff;
      nxt_manual = manual_ff;
      nxt_sqe    = sqe_ff;
      nxt_fef    = fef_ff;
      nxt_pol    = polarity_reversed_i;
      nxt_strap  = auto_strap_i;
      nxt_ack    = req;
      nxt_dat    = 32'h0000_0000;
      if (wr_hi) begin
         nxt_src    = dat_i[pxpc_pkg::PXPC_SRC_BIT];
         nxt_auto   = dat_i[pxpc_pkg::PXPC_AUTO_BIT];
         nxt_manual = dat_i[pxpc_pkg::PXPC_MANUAL_BIT];
         nxt_sqe    = dat_i[pxpc_pkg::PXPC_SQE_BIT];
      end
      if (wr_lo) begin
         nxt_fef = dat_i[pxpc_pkg::PXPC_FEF_BIT];
      end
      if (srst) begin
         nxt_src    = pxpc_pkg::PXPC_SRC_RST;
         nxt_auto   = pxpc_pkg::PXPC_AUTO_RST;
         nxt_manual = pxpc_pkg::PXPC_MANUAL_RST;
         nxt_sqe    = pxpc_pkg::PXPC_SQE_RST;
         nxt_fef    = fiber_mode_i;
      end
      if (req && !we_i) begin
         case (adr_i)
            pxpc_pkg::PXPC_CTRL_ADDR:   nxt_dat = {16'h0000, ctrl_rd};
            pxpc_pkg::PXPC_HWCFG_ADDR:  nxt_dat = {31'h0000_0000, strap_ff};
            default:                    nxt_dat = 32'h0000_0000;
         endcase
      end
   end

   // Mode decode; the reserved software code is passed on unchanged
   always_comb begin
      if (src_ff) begin
         nxt_mode = {auto_ff, manual_ff};
      end else if (auto_strap_i) begin
         nxt_mode = pxpc_pkg::PXPC_MDI_AUTO;
      end else if (manual_strap_i) begin
         nxt_mode = pxpc_pkg::PXPC_MDI_CROSS;
      end else begin
         nxt_mode = pxpc_pkg::PXPC_MDI_STRAIGHT;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_ff    <= pxpc_pkg::PXPC_SRC_RST;
         auto_ff   <= pxpc_pkg::PXPC_AUTO_RST;
         manual_ff <= pxpc_pkg::PXPC_MANUAL_RST;
         sqe_ff    <= pxpc_pkg::PXPC_SQE_RST;
         pol_ff    <= pxpc_pkg::PXPC_POL_RST;
         strap_ff  <= 1'h0;
         ack_ff    <= 1'h0;
         dat_ff    <= 32'h0000_0000;
         mode_ff   <= pxpc_pkg::PXPC_MDI_STRAIGHT;
      end else begin
         src_ff    <= nxt_src;
         auto_ff   <= nxt_auto;
         manual_ff <= nxt_manual;
         sqe_ff    <= nxt_sqe;
         pol_ff    <= nxt_pol;
         strap_ff  <= nxt_strap;
         ack_ff    <= nxt_ack;
         dat_ff    <= nxt_dat;
         mode_ff   <= nxt_mode;
      end
   end

   // Fiber strap is a level; the default is loaded on the first edge out of reset
   logic rst_seen_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_seen_ff <= 1'h1;
      end else begin
         rst_seen_ff <= 1'h0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fef_ff <= 1'h0;
      end else if (rst_seen_ff) begin
         fef_ff <= fiber_mode_i;
      end else begin
         fef_ff <= nxt_fef;
      end
   end

   assign dat_o                    = dat_ff;
   assign ack_o                    = ack_ff;
   assign crossover_mode_o         = mode_ff;
   assign heartbeat_test_disable_o = sqe_ff;
   assign far_end_fault_enable_o   = fef_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------
   // Crossover mode checks
   // ----------------------------------------
   override_mode_a: assert property (
      src_ff |=> crossover_mode_o == $past({auto_ff, manual_ff}))
      else $error("override mode mismatch");

   strap_auto_a: assert property (
      !src_ff && auto_strap_i |=> crossover_mode_o == pxpc_pkg::PXPC_MDI_AUTO)
      else $error("strap auto mode wrong");

   strap_manual_a: assert property (
      !src_ff && !auto_strap_i |=> crossover_mode_o == {1'b0, $past(manual_strap_i)})
      else $error("strap manual mode wrong");

   joint_auto_a: assert property (
      src_ff && auto_ff && !manual_ff |=> crossover_mode_o == pxpc_pkg::PXPC_MDI_AUTO)
      else $error("joint auto code wrong");

   straight_code_a: assert property (
      src_ff && !auto_ff && !manual_ff |=> crossover_mode_o == pxpc_pkg::PXPC_MDI_STRAIGHT)
      else $error("straight code wrong");

   cross_code_a: assert property (
      src_ff && !auto_ff && manual_ff |=> crossover_mode_o == pxpc_pkg::PXPC_MDI_CROSS)
      else $error("cross code wrong");

   reserved_code_a: assert property (
      src_ff && auto_ff && manual_ff |=> crossover_mode_o == pxpc_pkg::PXPC_MDI_RSVD)
      else $error("reserved code not passed");

   // ----------------------------------------
   // Register field checks
   // ----------------------------------------
   // The first edge out of reset holds reset values, not samples
   strap_read_a: assert property (
      !$past(rst_i) |-> strap_ff == $past(auto_strap_i))
      else $error("strap readback stale");

   hwcfg_read_a: assert property (
      req && !we_i && adr_i == pxpc_pkg::PXPC_HWCFG_ADDR
      |=> dat_o == {31'h0000_0000, $past(strap_ff)})
      else $error("strap view wrong");

   heartbeat_write_a: assert property (
      wr_hi |=> heartbeat_test_disable_o == $past(dat_i[pxpc_pkg::PXPC_SQE_BIT]))
      else $error("heartbeat bit not written");

   fault_write_a: assert property (
      wr_lo && !srst |=> far_end_fault_enable_o == $past(dat_i[pxpc_pkg::PXPC_FEF_BIT]))
      else $error("fault enable not written");

   fault_hold_a: assert property (
      !wr_lo && !srst && !rst_seen_ff |=> far_end_fault_enable_o == $past(fef_ff))
      else $error("fault enable moved");

   fiber_default_a: assert property (
      $fell(rst_seen_ff) |-> fef_ff == $past(fiber_mode_i))
      else $error("fault default wrong");

   polarity_read_a: assert property (
      req && !we_i && adr_i == pxpc_pkg::PXPC_CTRL_ADDR
      |=> dat_o[pxpc_pkg::PXPC_POL_BIT] == $past(pol_ff))
      else $error("polarity readback wrong");

   polarity_track_a: assert property (
      !$past(rst_i) |-> pol_ff == $past(polarity_reversed_i))
      else $error("polarity not tracked");

   soft_reset_a: assert property (
      srst |=> !src_ff && !auto_ff && !manual_ff && !sqe_ff && fef_ff == $past(fiber_mode_i))
      else $error("soft reset left fields");

   field_hold_a: assert property (
      !wr_hi && !srst |=> src_ff == $past(src_ff) && auto_ff == $past(auto_ff)
      && manual_ff == $past(manual_ff) && sqe_ff == $past(sqe_ff))
      else $error("control field moved");

   reserved_zero_a: assert property (
      ack_o |-> dat_o[12] == 1'b0 && dat_o[10:6] == 5'h00)
      else $error("reserved bits nonzero");

   unmapped_read_a: assert property (
      req && !we_i && adr_i != pxpc_pkg::PXPC_CTRL_ADDR
      && adr_i != pxpc_pkg::PXPC_HWCFG_ADDR |=> dat_o == 32'h0000_0000)
      else $error("unmapped read nonzero");

   // ----------------------------------------
   // Bus checks
   // ----------------------------------------
   // A fixed one-cycle answer lets the master hold its request briefly
   bus_answer_a: assert property (
      req |=> ack_o)
      else $error("request not answered");

   ack_pulse_a: assert property (
      ack_o |=> !ack_o)
      else $error("ack held two cycles");

   idle_data_a: assert property (
      !ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data outside ack");

   write_cov_c: cover property (wr_hi ##1 src_ff);
   auto_cov_c: cover property (crossover_mode_o == pxpc_pkg::PXPC_MDI_AUTO);
   rsvd_cov_c: cover property (crossover_mode_o == pxpc_pkg::PXPC_MDI_RSVD);
   srst_cov_c: cover property (srst);
   read_cov_c: cover property (ack_o && !we_i);
endmodule

/* pxpc_pkg.sv */
// Package for the crossover and polarity control register block.
// Assumes a 32-bit classic Wishbone slave with one aligned word per register.
package pxpc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0]  PXPC_REG_INDEX      = 8'h1B;
   localparam logic [9:0]  PXPC_CTRL_ADDR      = 10'h06C;
   localparam logic [9:0]  PXPC_HWCFG_ADDR     = 10'h080;
   localparam logic [9:0]  PXPC_RSTCTL_ADDR    = 10'h084;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int          PXPC_SRC_BIT        = 15;
   localparam int          PXPC_AUTO_BIT       = 14;
   localparam int          PXPC_MANUAL_BIT     = 13;
   localparam int          PXPC_SQE_BIT        = 11;
   localparam int          PXPC_FEF_BIT        = 5;
   localparam int          PXPC_POL_BIT        = 4;
   localparam int          PXPC_STRAP_BIT      = 0;
   localparam int          PXPC_SRST_BIT       = 0;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic        PXPC_SRC_RST        = 1'h0;
   localparam logic        PXPC_AUTO_RST       = 1'h0;
   localparam logic        PXPC_MANUAL_RST     = 1'h0;
   localparam logic        PXPC_SQE_RST        = 1'h0;
   localparam logic        PXPC_POL_RST        = 1'h0;
   // ----------------------------------------
   // Crossover modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      PXPC_MDI_STRAIGHT = 2'h0,
      PXPC_MDI_CROSS    = 2'h1,
      PXPC_MDI_AUTO     = 2'h2,
      PXPC_MDI_RSVD     = 2'h3
   } pxpc_mode_type;
endpackage

/* pxpc_top_tb_top.sv */
// Self-checking bench for the crossover and polarity control register.
// Assumes a one-cycle registered Wishbone answer and synchronous strap inputs.
`timescale 1ns/100ps
module pxpc_top_tb_top;
   logic        clk_i;
   logic        rst_i;
   logic        cyc_i;
   logic        stb_i;
   logic        we_i;
   logic [9:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        auto_strap_i;
   logic        manual_strap_i;
   logic        fiber_mode_i;
   logic        polarity_reversed_i;
   logic [1:0]  crossover_mode_o;
   logic        heartbeat_test_disable_o;
   logic        far_end_fault_enable_o;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          checked    = 0;
   integer      seed       = 79;

   pxpc_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .auto_strap_i, .manual_strap_i, .fiber_mode_i, .polarity_reversed_i,
      .crossover_mode_o, .heartbeat_test_disable_o, .far_end_fault_enable_o);

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic complete_run();
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      $display("[ERR] %0t %s", $time, msg);
      num_errors++;
   endtask

   // Entered just after a rising edge; returns just after one
   task automatic wb(input logic w, input logic [9:0] a, input logic [3:0] s,
                     input logic [31:0] d, input logic [31:0] e);
      int n;
      if (!w) begin
         exp_q.push_back(e);
      end
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail("no bus answer");
         complete_run();
      end
      @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic chk_out(input logic [1:0] m, input logic h, input logic f);
      @(negedge clk_i);
      checked++;
      if (crossover_mode_o !== m || heartbeat_test_disable_o !== h
          || far_end_fault_enable_o !== f) begin
         fail("control outputs");
      end
      @(posedge clk_i);
   endtask

   // Read results are compared in order of issue; sampled mid-cycle, where ack has settled
   always @(negedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0) begin
         checked++;
         if (exp_q.size() == 0) begin
            fail("unexpected read");
         end else if (dat_o !== exp_q.pop_front()) begin
            fail("read data");
         end
      end
   end

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   initial begin : main
      logic [31:0] d;
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 10'h000;
      sel_i = 4'h0;
      dat_i = 32'h0;
      auto_strap_i = 1'b0;
      manual_strap_i = 1'b0;
      fiber_mode_i = 1'b1;
      polarity_reversed_i = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, pxpc_pkg::PXPC_CTRL_ADDR, 4'hF, 32'h0, 32'h00000020); // fiber default
      chk_out(2'h0, 1'b0, 1'b1); // heartbeat on
      for (int i = 0; i < 4; i++) begin
         auto_strap_i <= i[1];
         manual_strap_i <= i[0];
         fiber_mode_i <= 1'b0;
         repeat (3) @(posedge clk_i);
         chk_out(i[1] ? 2'h2 : {1'b0, i[0]}, 1'b0, 1'b1); // strap mode
         wb(1'b0, pxpc_pkg::PXPC_HWCFG_ADDR, 4'hF, 32'h0, {31'h0, i[1]}); // strap
      end
      // software crossover codes 0 to 3, with fiber mode off
      for (int k = 0; k < 8; k++) begin
         d = $random(seed);
         d[15:13] = {1'b1, k[1:0]};
         auto_strap_i <= d[20];
         manual_strap_i <= d[21];
         polarity_reversed_i <= d[22];
         wb(1'b1, pxpc_pkg::PXPC_CTRL_ADDR, 4'hF, d, 32'h0); // straps ignored
         chk_out(k[1:0], d[11], d[5]); // software codes
         wb(1'b0, pxpc_pkg::PXPC_CTRL_ADDR, 4'hF, 32'h0,
            (d & 32'h0000E820) | {27'h0, d[22], 4'h0}); // reserved zero
      end
      // Lane 0 alone may only touch the fault enable
      wb(1'b1, pxpc_pkg::PXPC_CTRL_ADDR, 4'h1, 32'hFFFFFFFF, 32'h0); // fault enable
      wb(1'b0, pxpc_pkg::PXPC_CTRL_ADDR, 4'hF, 32'h0,
         (d & 32'h0000E800) | 32'h00000020 | {27'h0, d[22], 4'h0}); // polarity
      chk_out(d[14:13], d[11], 1'b1); // joint bits
      for (int f = 0; f < 2; f++) begin
         fiber_mode_i <= f[0];
         wb(1'b1, pxpc_pkg::PXPC_RSTCTL_ADDR, 4'h1, 32'h1, 32'h0); // soft reset
         wb(1'b0, pxpc_pkg::PXPC_CTRL_ADDR, 4'hF, 32'h0,
            {26'h0, f[0], polarity_reversed_i, 4'h0}); // fault default
         chk_out(auto_strap_i ? 2'h2 : {1'b0, manual_strap_i}, 1'b0, f[0]); // back
      end
      // Unmapped place answers zero and leaves the register alone
      wb(1'b1, 10'h3F0, 4'hF, 32'hFFFFFFFF, 32'h0);
      wb(1'b0, 10'h3F0, 4'hF, 32'h0, 32'h0); // unmapped read
      wb(1'b0, pxpc_pkg::PXPC_CTRL_ADDR, 4'hF, 32'h0,
         {26'h0, 1'b1, polarity_reversed_i, 4'h0}); // write ignored
      // Second reset with fiber mode off: fault enable must come up clear
      fiber_mode_i <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, pxpc_pkg::PXPC_CTRL_ADDR, 4'hF, 32'h0,
         {27'h0, polarity_reversed_i, 4'h0}); // copper default
      chk_out(auto_strap_i ? 2'h2 : {1'b0, manual_strap_i}, 1'b0, 1'b0); // after reset
      repeat (2) @(posedge clk_i);
      if (exp_q.size() != 0) begin
         fail("reads left unanswered");
      end
      complete_run();
   end
endmodule
